//--- common/swet_regs.vh
// register map, field layout, reset values and codes of the trigger block
`ifndef SWET_REGS_VH
`define SWET_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SWET_ADDR_STATUS      8'h17
`define SWET_ADDR_CLAMP_RISE  8'h66
`define SWET_ADDR_CLAMP_FALL  8'h67
`define SWET_ADDR_PIN5_RISE   8'h68
`define SWET_ADDR_PIN5_FALL   8'h69
`define SWET_ADDR_JACK_RISE   8'h6a
`define SWET_ADDR_JACK_FALL   8'h6b
`define SWET_ADDR_LVL_RISE    8'h6e
`define SWET_ADDR_LVL_FALL    8'h6f
`define SWET_ADDR_CTRL        8'h70

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define SWET_BUSY_BIT         9
`define SWET_IDX_RESET        9'h1ff
`define SWET_IDX_ABORT        9'h1ff
`define SWET_CUR_RESET        9'h000
`define SWET_CTRL_RESET       5'h00
`define SWET_CTRL_LVL_ENA     0
`define SWET_CTRL_CLAMP_JACK  1
`define SWET_CTRL_CLAMP_PIN5  2
`define SWET_CTRL_PIN5_INV    3
`define SWET_CTRL_PIN_SEL     4
`define SWET_WAIT_LAST        4'hf
`define SWET_NUM_COND         8

`endif

//--- tb/swet_step_engine.sv
// behavioural step engine that paces and acks sequencer steps
`timescale 1ns/1ps
`default_nettype none
module swet_step_engine (
    // clock and sequencer side
    input  wire logic       clk,
    input  wire logic       stepValid,
    // pacing chosen by the bench
    input  wire logic [3:0] gap,
    input  wire logic [3:0] steps,
    // step completion
    output var  logic       stepAck,
    output var  logic [3:0] stepWaitCode
);
    logic [3:0] cnt;
    logic [3:0] n;
    initial begin
        stepAck = 1'b0;
        stepWaitCode = 4'h0;
        cnt = 4'h0;
        n = 4'h0;
    end
    // code toggles outside acks so a stale value is never trusted
    always @(posedge clk) begin
        stepAck <= 1'b0;
        stepWaitCode <= ~stepWaitCode;
        if (!stepValid || stepAck) begin
            cnt <= 4'h0;
            if (!stepValid) n <= 4'h0;
        end else if (cnt >= gap) begin
            stepAck <= 1'b1;
            stepWaitCode <= (n + 4'h1 >= steps) ? 4'hf : 4'h0;
            n <= n + 4'h1;
        end else cnt <= cnt + 4'h1;
    end
endmodule // swet_step_engine
`default_nettype wire

//--- tb/swet_trigger_status_assertions.sv
// port checker of the sequencer trigger and status block
`timescale 1ns/1ps
`default_nettype none
module swet_trigger_status_assertions (
    // clock and register port
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        clkEn,
    input wire logic [7:0]  regAddr,
    input wire logic        regRd,
    input wire logic [15:0] regRdData,
    // step handshake and status
    input wire logic        stepAck,
    input wire logic [3:0]  stepWaitCode,
    input wire logic        sequenceAbortCommand,
    input wire logic        stepValid,
    input wire logic [8:0]  stepIndex,
    input wire logic        sequencerBusyFlag,
    input wire logic        sequencesDone,
    input wire logic        statusPinOut,
    input wire logic        statusPinOe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // abort excluded: it wins over a step ack in the same cycle
    sequence stepTaken;
        clkEn && stepValid && stepAck && !sequenceAbortCommand;
    endsequence
    sequence lastTaken;
        stepTaken ##0 stepWaitCode == 4'hf;
    endsequence
    busy_is_run_a: assert property (sequencerBusyFlag == stepValid)
        else $error("busy and run differ");
    last_step_a: assert property (lastTaken |=> !sequencerBusyFlag)
        else $error("run after last step");
    step_next_a: assert property (stepTaken ##0 stepWaitCode != 4'hf
        |=> stepIndex == $past(stepIndex) + 9'h001)
        else $error("index not advanced");
    abort_stop_a: assert property (clkEn && stepValid &&
        sequenceAbortCommand |=> !stepValid)
        else $error("abort ignored");
    done_pulse_a: assert property (sequencesDone |=> !sequencesDone)
        else $error("done too long");
    done_idle_a: assert property (sequencesDone |-> !stepValid)
        else $error("done while running");
    read_quiet_a: assert property (!$past(regRd) |->
        regRdData == 16'h0000)
        else $error("stray read data");
    status_read_a: assert property (clkEn && regRd && regAddr == 8'h17
        |=> regRdData == {6'h00, $past(sequencerBusyFlag), $past(stepIndex)})
        else $error("status read wrong");
    pin_idle_a: assert property (!statusPinOe |-> !statusPinOut)
        else $error("pin driven unselected");
    // a run only ends on its last step or on an abort
    sequence runGoesOn;
        clkEn && stepValid && !sequenceAbortCommand
            && !(stepAck && stepWaitCode == 4'hf);
    endsequence
    run_holds_a: assert property (runGoesOn |=> stepValid)
        else $error("run ended early");
    start_real_a: assert property ($rose(stepValid) |->
        stepIndex != 9'h1ff)
        else $error("abort index dispatched");
    pin_busy_a: assert property (statusPinOut |-> sequencerBusyFlag)
        else $error("pin busy while idle");
endmodule // swet_trigger_status_assertions
bind swet_trigger_status swet_trigger_status_assertions
    i_swet_trigger_status_assertions (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regRd(regRd), .regRdData(regRdData), .stepAck(stepAck),
    .stepWaitCode(stepWaitCode),
    .sequenceAbortCommand(sequenceAbortCommand), .stepValid(stepValid),
    .stepIndex(stepIndex), .sequencerBusyFlag(sequencerBusyFlag),
    .sequencesDone(sequencesDone), .statusPinOut(statusPinOut),
    .statusPinOe(statusPinOe));
`default_nettype wire

//--- tb/swet_trigger_status_bench.sv
// self-checking bench of the sequencer trigger and status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
failCount++; $display("FAIL %s exp %h got %h", n, e, s); end end
module swet_trigger_status_bench;
    logic        clk, arst_n, regWr, regRd, stepAck, stepValid, wasValid;
    logic        jackDetectLevel, generalPinFive, levelDetectOut, abortCmd;
    logic        busy, done, pinOut, pinOe, clkEn;
    logic [7:0]  regAddr;
    logic [15:0] regWrData, regRdData;
    logic [3:0]  waitCode, gap, steps;
    logic [8:0]  stepIndex, e, r, idx [8];
    logic [8:0]  expQ [$];
    logic [7:0]  ad [8] = '{8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b,
                           8'h6e, 8'h6f};
    logic [31:0] seed = 32'd59253;
    int          failCount, comparisons, doneCnt, d0, i;
    // block under test; its clock enable comes from the bench
    swet_trigger_status i_swet_trigger_status (.clk(clk), .arst_n(arst_n),
        .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .jackDetectLevel(jackDetectLevel), .generalPinFive(generalPinFive),
        .levelDetectOut(levelDetectOut), .stepAck(stepAck),
        .stepWaitCode(waitCode), .sequenceAbortCommand(abortCmd),
        .stepValid(stepValid), .stepIndex(stepIndex),
        .sequencerBusyFlag(busy), .sequencesDone(done),
        .statusPinOut(pinOut), .statusPinOe(pinOe));
    swet_step_engine i_swet_step_engine (.clk(clk), .stepValid(stepValid),
        .gap(gap), .steps(steps), .stepAck(stepAck), .stepWaitCode(waitCode));
    function automatic logic [8:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return {1'b0, seed[7:0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 `CHK("read", x, regRdData)
    endtask
    // model: a start index of 1ff never dispatches
    task automatic ex(input int s);
        if (idx[s] !== 9'h1ff) expQ.push_back(idx[s]);
    endtask
    task automatic pace();
        r = rnd();
        gap <= r[3:0];
        steps <= {2'b00, r[5:4]} + 4'h1;
    endtask
    // bounded wait until every expected sequence has run
    task automatic drain();
        int n;
        n = 0;
        repeat (8) @(negedge clk);
        while ((expQ.size() != 0 || stepValid !== 1'b0) && n < 3000) begin
            @(negedge clk);
            n++;
        end
        `CHK("queue", 0, expQ.size())
        `CHK("idle", 1'b0, stepValid)
        @(posedge clk);
    endtask
    task automatic results();
        if (failCount == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // every dispatch is matched against the model queue, in order
    always @(posedge clk) begin
        if (stepValid === 1'b1 && !wasValid) begin
            if (expQ.size() == 0) `CHK("dispatch", 1'b0, 1'b1)
            else begin
                e = expQ.pop_front();
                `CHK("start", e, stepIndex)
            end
        end
        if (done === 1'b1) doneCnt++;
        wasValid = stepValid;
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        results();
    end
    initial begin
        {arst_n, regWr, regRd, jackDetectLevel, wasValid} = 5'h00;
        {generalPinFive, levelDetectOut, abortCmd} = 3'h0;
        clkEn = 1'b1;
        {regAddr, regWrData, gap, steps} = 32'h00000001;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (i = 0; i < 8; i++) rd(ad[i], 16'h01ff);
        rd(8'h17, 16'h0000);
        rd(8'h40, 16'h0000);
        // in-range random indices, level fall muted with the abort code
        for (i = 0; i < 8; i++) begin
            idx[i] = (i == 7) ? 9'h1ff : rnd();
            wr(ad[i], {7'h00, idx[i]});
            rd(ad[i], {7'h00, idx[i]});
        end
        levelDetectOut <= 1'b1;
        drain();
        levelDetectOut <= 1'b0;
        drain();
        wr(8'h70, 16'h0001);
        d0 = doneCnt;
        ex(6);
        levelDetectOut <= 1'b1;
        drain();
        ex(7);
        levelDetectOut <= 1'b0;
        drain();
        `CHK("done", 1'b1, doneCnt > d0)
        // clamp follows jack, then pin five: two events at once
        for (i = 0; i < 2; i++) begin
            wr(8'h70, i ? 16'h0005 : 16'h0003);
            pace();
            ex(0);
            ex(4 - 2 * i);
            if (i) generalPinFive <= 1'b1; else jackDetectLevel <= 1'b1;
            drain();
            ex(1);
            ex(5 - 2 * i);
            if (i) generalPinFive <= 1'b0; else jackDetectLevel <= 1'b0;
            drain();
        end
        // frozen clock enable: an edge waits until the block runs again
        clkEn <= 1'b0;
        levelDetectOut <= 1'b1;
        ex(6);
        repeat (4) @(negedge clk);
        `CHK("frozen", 1'b0, stepValid)
        @(posedge clk);
        clkEn <= 1'b1;
        drain();
        // slow run aborted; the queued one must still run
        wr(8'h70, 16'h0015);
        gap <= 4'hf;
        steps <= 4'h8;
        ex(0);
        ex(2);
        generalPinFive <= 1'b1;
        repeat (8) @(negedge clk);
        `CHK("pin", 2'b11, {pinOe, pinOut})
        `CHK("busy", 1'b1, busy)
        rd(8'h17, {7'h01, idx[0]});
        @(posedge clk);
        abortCmd <= 1'b1;
        @(posedge clk);
        abortCmd <= 1'b0;
        drain();
        // eight steps from its start: index stays on the last one
        rd(8'h17, {7'h00, idx[2] + 9'd7});
        // polarity flip of the high pin is a fall of pin and clamp
        ex(1);
        ex(3);
        wr(8'h70, 16'h001d);
        drain();
        results();
    end
endmodule // swet_trigger_status_bench
`default_nettype wire

//--- verilog/swet_trigger_status.v
// event trigger dispatch, queue and status readback of the write sequencer
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "swet_regs.vh"

module swet_trigger_status (
    // clock, reset, enable
    input  wire        clk,
    input  wire        arst_n,
    input  wire        clkEn,
    // register port
    input  wire [7:0]  regAddr,
    input  wire [15:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [15:0] regRdData,
    // trigger sources
    input  wire        jackDetectLevel,
    input  wire        generalPinFive,
    input  wire        levelDetectOut,
    // step engine handshake
    input  wire        stepAck,
    input  wire [3:0]  stepWaitCode,
    input  wire        sequenceAbortCommand,
    output reg         stepValid,
    output reg  [8:0]  stepIndex,
    // status towards interrupt controller and pin
    output reg         sequencerBusyFlag,
    output reg         sequencesDone,
    output reg         statusPinOut,
    output reg         statusPinOe
);

    // ------------------------------------------------------------------
    // states and slot order (lowest slot wins a tie)
    // ------------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;
    localparam [3:0] SLOT_NONE = 4'h8;

    // map a register offset to its start index slot
    function [3:0] slotOf;
        input [7:0] a;
        begin
            case (a)
                `SWET_ADDR_CLAMP_RISE: slotOf = 4'h0;
                `SWET_ADDR_CLAMP_FALL: slotOf = 4'h1;
                `SWET_ADDR_PIN5_RISE:  slotOf = 4'h2;
                `SWET_ADDR_PIN5_FALL:  slotOf = 4'h3;
                `SWET_ADDR_JACK_RISE:  slotOf = 4'h4;
                `SWET_ADDR_JACK_FALL:  slotOf = 4'h5;
                `SWET_ADDR_LVL_RISE:   slotOf = 4'h6;
                `SWET_ADDR_LVL_FALL:   slotOf = 4'h7;
                default:               slotOf = SLOT_NONE;
            endcase
        end
    endfunction

    // lowest pending slot, or none
    function [3:0] firstSet;
        input [7:0] p;
        integer k;
        begin
            firstSet = SLOT_NONE;
            for (k = 7; k >= 0; k = k - 1) begin
                if (p[k]) begin
                    firstSet = k[3:0];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg  [8:0] startIdx_q [0:7];
    reg  [4:0] ctrl_q;
    reg  [2:0] jackSync_q;
    reg  [2:0] pinSync_q;
    reg        jackLvl_q;
    reg        pinLvl_q;
    reg        clampLvl_q;
    reg        levelPrev_q;
    reg        jackPrev_q;
    reg        pinPrev_q;
    reg  [7:0] pending_q;
    reg  [7:0] pending_d;
    reg        state_q;
    reg        state_d;
    reg  [8:0] curIdx_q;
    reg  [8:0] curIdx_d;
    reg        done_d;
    reg  [7:0] events;
    reg  [3:0] pick;
    reg        pinFiveIn;
    reg        clampNow;
    wire [3:0] wrSlot;
    integer    i;

    assign wrSlot = slotOf(regAddr);

    // ------------------------------------------------------------------
    // source synchronisers and level filters
    // ------------------------------------------------------------------
    // pins are asynchronous: a change counts once stages 2 and 3 agree
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            jackSync_q <= 3'h0;
            pinSync_q  <= 3'h0;
            jackLvl_q  <= 1'b0;
            pinLvl_q   <= 1'b0;
        end else if (clkEn) begin
            jackSync_q <= {jackSync_q[1:0], jackDetectLevel};
            pinSync_q  <= {pinSync_q[1:0], generalPinFive};
            if (jackSync_q[1] == jackSync_q[2]) begin
                jackLvl_q <= jackSync_q[2];
            end
            if (pinSync_q[1] == pinSync_q[2]) begin
                pinLvl_q <= pinSync_q[2];
            end
        end
    end

    // pin five level after its polarity setting, clamp from the selection
    always @* begin
        pinFiveIn = pinLvl_q ^ ctrl_q[`SWET_CTRL_PIN5_INV];
        clampNow  = (ctrl_q[`SWET_CTRL_CLAMP_JACK] & jackLvl_q)
                  | (ctrl_q[`SWET_CTRL_CLAMP_PIN5] & pinFiveIn);
    end

    // edge events; previous levels kept as flops, one edge one event
    always @* begin
        events[0] =  clampNow & ~clampLvl_q;
        events[1] = ~clampNow &  clampLvl_q;
        events[2] =  pinFiveIn & ~pinPrev_q;
        events[3] = ~pinFiveIn &  pinPrev_q;
        events[4] =  jackLvl_q & ~jackPrev_q;
        events[5] = ~jackLvl_q &  jackPrev_q;
        // a single enable gates both level-detect edges
        events[6] = ctrl_q[`SWET_CTRL_LVL_ENA]
                  &  levelDetectOut & ~levelPrev_q;
        events[7] = ctrl_q[`SWET_CTRL_LVL_ENA]
                  & ~levelDetectOut &  levelPrev_q;
    end

    // previous levels for the edge detectors; the pin edge is taken after
    // the polarity setting, so flipping that bit is an edge as well
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            jackPrev_q  <= 1'b0;
            pinPrev_q   <= 1'b0;
            clampLvl_q  <= 1'b0;
            levelPrev_q <= 1'b0;
        end else if (clkEn) begin
            jackPrev_q  <= jackLvl_q;
            pinPrev_q   <= pinFiveIn;
            clampLvl_q  <= clampNow;
            levelPrev_q <= levelDetectOut;  // same clock, no synchroniser
        end
    end

    // ------------------------------------------------------------------
    // queue and dispatch
    // ------------------------------------------------------------------
    // pending bits hold one request per condition; a new edge of a
    // condition already waiting merges with it (limitation)
    always @* begin
        pending_d = pending_q | events;
        state_d   = state_q;
        curIdx_d  = curIdx_q;
        done_d    = 1'b0;
        pick      = firstSet(pending_q);
        case (state_q)
            ST_IDLE: begin
                if (pick != SLOT_NONE) begin
                    // set wins: a new edge on the same slot re-arms it
                    pending_d[pick[2:0]] = events[pick[2:0]];
                    if (startIdx_q[pick[2:0]] == `SWET_IDX_ABORT) begin
                        // abort code: drop the sequence, run nothing
                        done_d = (pending_d == 8'h00);
                    end else begin
                        state_d  = ST_RUN;
                        curIdx_d = startIdx_q[pick[2:0]];
                    end
                end
            end
            ST_RUN: begin
                if (sequenceAbortCommand) begin
                    state_d = ST_IDLE;
                    done_d  = (pending_d == 8'h00);
                end else if (stepAck) begin
                    if (stepWaitCode == `SWET_WAIT_LAST) begin
                        state_d = ST_IDLE;
                        done_d  = (pending_d == 8'h00);
                    end else begin
                        curIdx_d = curIdx_q + 9'h001;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // sequencer state, current index and outputs
    // reset clears the index, queue, state and outputs; step memory outside keeps it
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pending_q         <= 8'h00;
            state_q           <= ST_IDLE;
            curIdx_q          <= `SWET_CUR_RESET;
            stepValid         <= 1'b0;
            stepIndex         <= `SWET_CUR_RESET;
            sequencerBusyFlag <= 1'b0;
            sequencesDone     <= 1'b0;
            statusPinOut      <= 1'b0;
            statusPinOe       <= 1'b0;
        end else if (clkEn) begin
            pending_q         <= pending_d;
            state_q           <= state_d;
            curIdx_q          <= curIdx_d;
            stepValid         <= (state_d == ST_RUN);
            stepIndex         <= curIdx_d;
            sequencerBusyFlag <= (state_d == ST_RUN);
            sequencesDone     <= done_d;
            statusPinOut      <= (state_d == ST_RUN)
                               & ctrl_q[`SWET_CTRL_PIN_SEL];
            statusPinOe       <= ctrl_q[`SWET_CTRL_PIN_SEL];
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // indices above 0FFh other than the abort code are stored as written;
    // their effect is undefined for software
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (i = 0; i < `SWET_NUM_COND; i = i + 1) begin
                startIdx_q[i] <= `SWET_IDX_RESET;
            end
            ctrl_q <= `SWET_CTRL_RESET;
        end else if (clkEn && regWr) begin
            if (wrSlot != SLOT_NONE) begin
                startIdx_q[wrSlot[2:0]] <= regWrData[8:0];
            end
            if (regAddr == `SWET_ADDR_CTRL) begin
                ctrl_q <= regWrData[4:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // register reads, data in the cycle after the strobe
    // ------------------------------------------------------------------
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= 16'h0000;
        end else if (clkEn) begin
            if (!regRd) begin
                regRdData <= 16'h0000;
            end else if (regAddr == `SWET_ADDR_STATUS) begin
                regRdData <= {6'h00, state_q, curIdx_q};
            end else if (regAddr == `SWET_ADDR_CTRL) begin
                regRdData <= {11'h000, ctrl_q};
            end else if (wrSlot != SLOT_NONE) begin
                regRdData <= {7'h00, startIdx_q[wrSlot[2:0]]};
            end else begin
                regRdData <= 16'h0000;  // unmapped reads as zero
            end
        end
    end

endmodule // swet_trigger_status

`default_nettype wire
